// File: hw/drl_pkg.sv
/*
  Constants for the DDR read latency block: latency table, opcodes and
  the padding parameter of the query identification area.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package drl_pkg;
  // Latency codes
  localparam logic [1:0] LAT_CODE_00 = 2'h0;
  localparam logic [1:0] LAT_CODE_01 = 2'h1;
  localparam logic [1:0] LAT_CODE_10 = 2'h2;
  localparam logic [1:0] LAT_CODE_11 = 2'h3;
  // Serial clock ceilings in MHz
  localparam int MAX_SCK_MHZ_CODE_11 = 50;
  localparam int MAX_SCK_MHZ_OTHER   = 66;
  // Latency code bit positions in the nonvolatile configuration register
  localparam int LAT_CODE_HIGH_POS = 7;
  localparam int LAT_CODE_LOW_POS  = 6;
  localparam logic [7:0] NV_CONFIG_RESET = 8'h00;
  // Opcodes, 3-byte and 4-byte address forms
  localparam logic [7:0] OP_FAST_DDR_3B = 8'h0d;
  localparam logic [7:0] OP_FAST_DDR_4B = 8'h0e;
  localparam logic [7:0] OP_DUAL_DDR_3B = 8'hbd;
  localparam logic [7:0] OP_DUAL_DDR_4B = 8'hbe;
  localparam logic [7:0] OP_QUAD_DDR_3B = 8'hed;
  localparam logic [7:0] OP_QUAD_DDR_4B = 8'hee;
  // Mode and latency cycles, indexed by latency code: {code00, code01, code10, code11}
  localparam logic [3:0] FAST_MODE [4] = '{4'h4, 4'h4, 4'h4, 4'h4};
  localparam logic [3:0] FAST_LAT  [4] = '{4'h2, 4'h4, 4'h5, 4'h1};
  localparam logic [3:0] DUAL_MODE [4] = '{4'h2, 4'h2, 4'h2, 4'h2};
  localparam logic [3:0] DUAL_LAT  [4] = '{4'h4, 4'h5, 4'h6, 4'h2};
  localparam logic [3:0] QUAD_MODE [4] = '{4'h1, 4'h1, 4'h1, 4'h1};
  localparam logic [3:0] QUAD_LAT  [4] = '{4'h6, 4'h7, 4'h8, 4'h3};
  // Padding parameter
  localparam logic [7:0] PAD_ID      = 8'hf0;
  localparam logic [7:0] PAD_LEN     = 8'h0f;
  localparam logic [7:0] PAD_FILL    = 8'hff;
  localparam logic [7:0] PAD_OFFSET  = 8'h00;
  localparam int         QUERY_BYTES = 32;
  typedef enum logic [1:0] {KIND_FAST, KIND_DUAL, KIND_QUAD, KIND_NONE} drl_kind_t;
endpackage

// File: hw/drl_edge_sync.sv
/*
  Two-flop synchroniser with rise and fall pulses taken after the second flop.
  Assumes the input is asynchronous to core_clk.
*/
`timescale 1ns/1ps
module drl_edge_sync #(
  // Idle level of the pin; reset to it so no false edge follows reset
  parameter logic IDLE_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Signal
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      meta_q <= IDLE_LEVEL;
      sync_q <= IDLE_LEVEL;
      prev_q <= IDLE_LEVEL;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;
endmodule // drl_edge_sync

// File: hw/drl_ddr_read_latency.sv
/*
  DDR read latency sequencer of a serial flash: counts mode and latency
  cycles after the address and opens the data drive; serves the padding
  parameter of the query identification area.
  Assumes the host drives sck and cs_n, and starts the sequence by
  pulsing addr_done in the last address cycle.
*/
// Operation
// (R1) Code 11b is the lowest DDR row and the host keeps sck at or below 50 MHz with it.
// (R2) With code 11b fast DDR read has 4 mode cycles then 1 latency cycle.
// (R3) With code 11b dual DDR has 2 mode and 2 latency cycles, quad 1 mode and 3 latency.
// (R4) Code 00b allows 66 MHz with fast 4/2, dual 2/4 and quad 1/6 cycles.
// (R5) Code 01b allows 66 MHz with fast 4/4, dual 2/5 and quad 1/7 cycles.
// (R6) Code 10b allows 66 MHz with fast 4/5, dual 2/6 and quad 1/8 cycles.
// (R7) The query area holds a padding parameter F0h, length 0Fh, filled with FFh.
// (R8) A reader takes the length byte as the count of following bytes to the next parameter.
// (R9) Padding may repeat with other lengths and is skipped by the reader unread.
// (R10) The latency code is bits 7:6 of the nonvolatile configuration register.
// (R11) Opcodes 0Dh/0Eh, BDh/BEh, EDh/EEh are fast, dual and quad, 3-byte then 4-byte.
// (R12) Mode bits are sampled in mode cycles, output is silent in latency, data follows.
`timescale 1ns/1ps
module drl_ddr_read_latency
  import drl_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Serial link from host
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_in,
  // Command decode from the front end, same clock
  input  wire logic [7:0] opcode,
  input  wire logic       addr_done,
  // Configuration
  input  wire logic       nv_config_we,
  input  wire logic [7:0] nv_config_wdata,
  output logic [7:0]      nonvolatile_config_register,
  // Sequencer results
  output logic [7:0]      mode_bits,
  output logic            data_drive_en,
  output logic [6:0]      max_sck_mhz,
  // Query identification area read port
  input  wire logic [4:0] query_addr,
  output logic [7:0]      query_data
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {ST_IDLE, ST_MODE, ST_LAT, ST_DATA} drl_state_t;

  drl_state_t state_q;
  drl_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] mode_q;
  logic [7:0] nvcr_q;
  logic [7:0] qdata_q;
  logic       drive_q;
  logic       sck_rise;
  logic       cs_lvl;
  logic [3:0] io_meta_q;
  logic [3:0] io_sync_q;

  drl_edge_sync u_sck_sync (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .async_in  (sck),
    .level_out (),
    .rise_out  (sck_rise),
    .fall_out  ()
  );

  // Select idles high, so its synchroniser resets deselected
  drl_edge_sync #(
    .IDLE_LEVEL (1'b1)
  ) u_cs_sync (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .async_in  (cs_n),
    .level_out (cs_lvl),
    .rise_out  (),
    .fall_out  ()
  );

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      io_meta_q <= 4'h0;
      io_sync_q <= 4'h0;
    end
    else
    begin
      io_meta_q <= io_in;
      io_sync_q <= io_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Latency code and table selection
  wire [1:0] lat_code = {nvcr_q[LAT_CODE_HIGH_POS], nvcr_q[LAT_CODE_LOW_POS]}; // [R10]

  wire is_fast = (opcode == OP_FAST_DDR_3B) || (opcode == OP_FAST_DDR_4B); // [R11]
  wire is_dual = (opcode == OP_DUAL_DDR_3B) || (opcode == OP_DUAL_DDR_4B); // [R11]
  wire is_quad = (opcode == OP_QUAD_DDR_3B) || (opcode == OP_QUAD_DDR_4B); // [R11]
  wire drl_kind_t kind = is_fast ? KIND_FAST : is_dual ? KIND_DUAL :
                         is_quad ? KIND_QUAD : KIND_NONE;

  // Package tables are indexed directly by the latency code
  wire [1:0] tix = lat_code;
  wire [3:0] sel_mode = (kind == KIND_FAST) ? FAST_MODE[tix] :
                        (kind == KIND_DUAL) ? DUAL_MODE[tix] : QUAD_MODE[tix]; // [R2][R3]
  wire [3:0] sel_lat  = (kind == KIND_FAST) ? FAST_LAT[tix] :
                        (kind == KIND_DUAL) ? DUAL_LAT[tix] : QUAD_LAT[tix]; // [R4][R5][R6]
  logic [3:0] lat_hold_q;

  // Ceiling reported for the host; the device cannot police sck itself
  assign max_sck_mhz = (lat_code == LAT_CODE_11) ? 7'(MAX_SCK_MHZ_CODE_11)
                                                 : 7'(MAX_SCK_MHZ_OTHER); // [R1]

  wire start = addr_done && !cs_lvl && (kind != KIND_NONE);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: one count per sck rising edge
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE:
        if (start)
        begin
          state_d = ST_MODE;
          cnt_d   = sel_mode;
        end
      ST_MODE:
        if (sck_rise)
        begin
          if (cnt_q == 4'h1)
          begin
            state_d = ST_LAT;
            cnt_d   = lat_hold_q;
          end
          else
            cnt_d = cnt_q - 4'h1;
        end
      ST_LAT:
        if (sck_rise)
        begin
          if (cnt_q == 4'h1)
            state_d = ST_DATA; // [R12]
          else
            cnt_d = cnt_q - 4'h1;
        end
      ST_DATA:
        state_d = ST_DATA;
      default:
        state_d = ST_IDLE;
    endcase
    if (cs_lvl)
      state_d = ST_IDLE;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_q    <= ST_IDLE;
      cnt_q      <= 4'h0;
      lat_hold_q <= 4'h0;
      mode_q     <= 8'h00;
      drive_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      drive_q <= (state_d == ST_DATA); // [R12]
      if (start && state_q == ST_IDLE)
        lat_hold_q <= sel_lat;
      if (state_q == ST_MODE && sck_rise)
        mode_q <= {mode_q[3:0], io_sync_q}; // [R12]
    end
  end

  assign mode_bits     = mode_q;
  assign data_drive_en = drive_q;

  ////////////////////////////////////////////////////////////////////////
  // Configuration register, latency code in the top bits
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      nvcr_q <= NV_CONFIG_RESET;
    else if (nv_config_we)
      nvcr_q <= nv_config_wdata; // [R10]
  end
  assign nonvolatile_config_register = nvcr_q;

  ////////////////////////////////////////////////////////////////////////
  // Padding parameter; a reader skips it by its length byte
  wire [7:0] qoff = {3'h0, query_addr} - PAD_OFFSET;
  wire [7:0] qbyte = (qoff == 8'h00) ? PAD_ID :
                     (qoff == 8'h01) ? PAD_LEN : PAD_FILL; // [R7][R9]
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      qdata_q <= 8'h00;
    else
      qdata_q <= qbyte; // [R7]
  end
  assign query_data = qdata_q;

  ////////////////////////////////////////////////////////////////////////
  chk_pad_header: assert property (@(posedge core_clk) disable iff (sys_rst) // [R7]
    (query_addr == 5'h01) |=> (query_data == 8'h0f))
    else $error("padding length byte wrong");
  chk_pad_id: assert property (@(posedge core_clk) disable iff (sys_rst) // [R7]
    (query_addr == 5'h00) |=> (query_data == 8'hf0))
    else $error("padding id byte wrong");
  chk_pad_fill: assert property (@(posedge core_clk) disable iff (sys_rst) // [R9]
    (query_addr > 5'h01 && query_addr <= 5'h10) |=> (query_data == 8'hff))
    else $error("padding fill byte wrong");
  chk_ceiling_low: assert property (@(posedge core_clk) disable iff (sys_rst) // [R1]
    (lat_code == 2'h3) |-> (max_sck_mhz == 7'd50))
    else $error("code 11 ceiling wrong");
  chk_ceiling_high: assert property (@(posedge core_clk) disable iff (sys_rst) // [R4]
    (lat_code != 2'h3) |-> (max_sck_mhz == 7'd66))
    else $error("66 MHz ceiling wrong");
  chk_fast_11_lat: assert property (@(posedge core_clk) disable iff (sys_rst) // [R2]
    (is_fast && lat_code == 2'h3) |-> (sel_mode == 4'h4 && sel_lat == 4'h1))
    else $error("fast code 11 cycles wrong");
  chk_dual_quad_11: assert property (@(posedge core_clk) disable iff (sys_rst) // [R3]
    (lat_code == 2'h3) |-> ((is_dual -> sel_lat == 4'h2) && (is_quad -> sel_lat == 4'h3)))
    else $error("dual or quad code 11 cycles wrong");
  chk_quad_table: assert property (@(posedge core_clk) disable iff (sys_rst) // [R5]
    is_quad |-> (sel_mode == 4'h1 && sel_lat == 4'(4'h6 + lat_code) || lat_code == 2'h3))
    else $error("quad latency table wrong");
  chk_code_bits: assert property (@(posedge core_clk) disable iff (sys_rst) // [R10]
    nv_config_we |=> (lat_code == $past(nv_config_wdata[7:6])))
    else $error("latency code not from top bits");
  chk_silent_lat: assert property (@(posedge core_clk) disable iff (sys_rst) // [R12]
    (state_q == ST_MODE || state_q == ST_LAT) |-> !data_drive_en)
    else $error("drive during mode or latency");
  chk_drive_end: assert property (@(posedge core_clk) disable iff (sys_rst) // [R12]
    (state_q == ST_LAT && cnt_q == 4'h1 && sck_rise && !cs_lvl) |=> data_drive_en)
    else $error("drive not opened after latency");
endmodule // drl_ddr_read_latency

// File: tb/drl_host_model.sv
/*
  Host controller model: drives sck, cs_n and the io pins of a DDR read.
  Assumes the bench opens, clocks and closes each frame through its tasks.
*/
`timescale 1ns/1ps
module drl_host_model (
  // Link pins
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io_in
);
  localparam int HALF = 40;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h5;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Select first, clock later; sck stands still outside frames
  task automatic open_frame();
  begin
    cs_n = 1'b0;
    #HALF;
  end
  endtask
  // 80 ns period (12.5 MHz) keeps well under the ceiling of every row, 50 MHz at the lowest
  task automatic rises(input int n, input logic [3:0] nib);
  begin
    repeat (n)
    begin
      io_in = nib;
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
    end
  end
  endtask
  // Released pins flip so a stale value never passes for data
  task automatic close_frame();
  begin
    cs_n = 1'b1;
    io_in = ~io_in;
    #HALF;
  end
  endtask
endmodule // drl_host_model

// File: tb/drl_ddr_read_latency_tb.sv
/*
  Self-checking bench for the DDR read latency sequencer.
  Assumes drl_host_model drives the link pins at an 80 ns sck period.
*/
`timescale 1ns/1ps
module drl_ddr_read_latency_tb;
  logic       core_clk;
  logic       sys_rst;
  logic       sck;
  logic       cs_n;
  logic [3:0] io_in;
  logic [7:0] opcode;
  logic       addr_done;
  logic       nv_config_we;
  logic [7:0] nv_config_wdata;
  logic [7:0] nv_cfg;
  logic [7:0] mode_bits;
  logic       data_drive_en;
  logic [6:0] max_sck_mhz;
  logic [4:0] query_addr;
  logic [7:0] query_data;
  int         fail_count = 0;
  int         total_checks = 0;
  localparam int MD[3] = '{4, 2, 1};
  localparam int LT[3][4] = '{'{2, 4, 5, 1}, '{4, 5, 6, 2}, '{6, 7, 8, 3}};
  localparam logic [7:0] OPS[6] = '{8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee};
  ////////////////////////////////////////////////////////////////////////////////
  drl_host_model host (.sck(sck), .cs_n(cs_n), .io_in(io_in));
  drl_ddr_read_latency uut (.core_clk(core_clk), .sys_rst(sys_rst), .sck(sck),
    .cs_n(cs_n), .io_in(io_in), .opcode(opcode), .addr_done(addr_done),
    .nv_config_we(nv_config_we), .nv_config_wdata(nv_config_wdata),
    .nonvolatile_config_register(nv_cfg), .mode_bits(mode_bits),
    .data_drive_en(data_drive_en), .max_sck_mhz(max_sck_mhz),
    .query_addr(query_addr), .query_data(query_data));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_bit(input string n, input logic e, input logic g);
  begin
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s exp %b got %b", n, e, g);
    end
  end
  endtask
  task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
  begin
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  end
  endtask
  task automatic tick(input int n);
  begin
    repeat (n) @(posedge core_clk);
    #1;
  end
  endtask
  // Bounded wait: sync plus register adds at most a few core cycles
  task automatic wait_drive(input logic e);
    int i;
  begin
    for (i = 0; i < 12 && data_drive_en !== e; i++)
      tick(1);
    cmp_bit("data_drive_en", e, data_drive_en);
  end
  endtask
  task automatic set_code(input logic [1:0] c);
  begin
    tick(1);
    nv_config_we = 1'b1;
    nv_config_wdata = {c, 6'h2a};
    tick(1);
    nv_config_we = 1'b0;
    tick(1);
    cmp_byte("nv_config", {c, 6'h2a}, nv_cfg);
    cmp_byte("max_sck_mhz", (c == 2'h3) ? 8'h32 : 8'h42, {1'b0, max_sck_mhz});
  end
  endtask
  // One frame: m mode rises, l latency rises, drive expected only after the last
  task automatic run(input logic [1:0] c, input logic [7:0] op, input int m, input int l,
                     input logic e);
    logic [3:0] a;
  begin
    a = {c, op[1:0]};
    set_code(c);
    host.open_frame();
    tick(1);
    opcode = op;
    addr_done = 1'b1;
    tick(1);
    addr_done = 1'b0;
    host.rises(m, a);
    tick(2);
    if (e && m > 1)
      cmp_byte("mode_bits", {a, a}, mode_bits);
    if (e)
      cmp_byte("mode_low", {4'h0, a}, {4'h0, mode_bits[3:0]});
    host.rises(l - 1, ~a);
    tick(2);
    cmp_bit("silent", 1'b0, data_drive_en);
    host.rises(1, ~a);
    wait_drive(e);
    host.close_frame();
    wait_drive(1'b0);
  end
  endtask
  task automatic read_q(input int a, output logic [7:0] d);
  begin
    query_addr = 5'(a);
    tick(1);
    d = query_data;
  end
  endtask
  task automatic query_test();
    int p;
    logic [7:0] b;
    logic [7:0] ln;
  begin
    read_q(0, b);
    cmp_byte("pad_id", 8'hf0, b);
    read_q(1, ln);
    cmp_byte("pad_len", 8'h0f, ln);
    // Walk to the next parameter start, reading and checking each fill byte
    for (p = 2; p <= 1 + int'(ln); p++)
    begin
      read_q(p, b);
      cmp_byte("pad_fill", 8'hff, b);
    end
  end
  endtask
  task automatic wrap_up();
  begin
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst = 1'b1;
    opcode = 8'h00;
    addr_done = 1'b0;
    nv_config_we = 1'b0;
    nv_config_wdata = 8'h00;
    query_addr = 5'h00;
    repeat (5) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    tick(3);
    cmp_byte("nv_reset", 8'h00, nv_cfg);
    cmp_byte("max_reset", 8'h42, {1'b0, max_sck_mhz});
    cmp_bit("drive_reset", 1'b0, data_drive_en);
    for (int c = 0; c < 4; c++)
      for (int j = 0; j < 6; j++)
        run(2'(c), OPS[j], MD[j / 2], LT[j / 2][c], 1'b1);
    $display("test latency table done");
    run(2'h0, 8'h0b, 4, 2, 1'b0);
    $display("test refused opcode done");
    query_test();
    $display("test query padding done");
    wrap_up();
  end
  initial
  begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule // drl_ddr_read_latency_tb
